//--- src/ioc_indicator_ctrl.sv
// Indicator output controller: source selection, stretch, blink and APB registers.
//
// Functional notes
// RULE_01 - Each output's 4-bit selector codes 0 to 7 show collision, error, duplex, duplex-or-collision, speed, link, transmit and receive.
// RULE_02 - Codes 8, 9 and A show activity, link with receive and link with activity, and output 0 does not offer codes 8 and 9.
// RULE_03 - Codes B, C and D blink the output on activity, transmit and receive instead of a steady level.
// RULE_04 - Code E blinks output 0 on collision and shows the interrupt indication on output 2.
// RULE_05 - Code F holds the output at logic one, its inactive level.
// RULE_06 - Hardware reset loads selector 2 with A, selectors 0 and 1 with 4, and the top reserved nibble with 4.
// RULE_07 - A global 3-bit stretch length extends each event from none up to 1.3 to 2.7 s and resets to 4.
// RULE_08 - A global 3-bit blink rate selects a period from 42 ms to 670 ms, codes 5 to 7 are reserved, and it resets to 1.
// RULE_09 - Link type select 0 makes an output active for a 10BASE-T link.
// RULE_10 - Link type select 5 means 100BASE-X, others are reserved, and output 0 resets to 5 while the rest reset to 0.
// RULE_11 - Software reset leaves every selector, stretch, blink and link type field unchanged.
// RULE_12 - Stretch and blink times run on a prescaled clock and start fresh on a new event after idle.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps

module ioc_indicator_ctrl #(
	parameter int unsigned TICK_CYC = ioc_pkg::TICK_CYC
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link status from the transceiver core.
	input wire logic collision,
	input wire logic rxError,
	input wire logic txActive,
	input wire logic rxActive,
	input wire logic fullDuplex,
	input wire logic speed100,
	input wire logic linkUp,
	input wire logic intPending,
	input wire logic swReset,
	// Indicator pins, low when lit.
	output logic [2:0] indicatorN
);

	localparam logic [14:0] TICK_LAST = 15'(TICK_CYC - 1);

	logic [15:0] srcSel_q;
	logic [15:0] timing_q;
	logic [31:0] prdata_q;
	logic [2:0] indicatorN_q;
	logic [ioc_pkg::NUM_EV-1:0] evIn;
	logic [ioc_pkg::NUM_EV-1:0] evS;
	logic [ioc_pkg::NUM_IND-1:0] blinkOn;
	logic [ioc_pkg::NUM_IND-1:0] litNow;
	logic [11:0] stretchLen;
	logic [11:0] halfMs;
	logic wrEn;
	logic setup;
	logic unmapped;

	// Length of a stretch in ticks; zero disables stretching.
	function automatic logic [11:0] stretchMs(input logic [2:0] sel);
		if (sel == 3'h0) begin
			return 12'h000;
		end
		return 12'(ioc_pkg::STRETCH_BASE_MS << (sel - 3'h1));
	endfunction

	// Half blink period in ticks; reserved rates fall back to the slowest.
	function automatic logic [11:0] blinkHalf(input logic [2:0] sel);
		logic [2:0] s;
		s = (sel > ioc_pkg::BLINK_MAX_SEL) ? ioc_pkg::BLINK_MAX_SEL : sel;
		return 12'(ioc_pkg::BLINK_HALF_MS << s);
	endfunction

	// Returns {blink, level}; blink set means the output follows the blink phase.
	function automatic logic [1:0] pickSource(input int idx, input logic [3:0] code,
		input logic [2:0] spd, input logic [ioc_pkg::NUM_EV-1:0] ev);
		logic activity;
		logic spdOk;
		activity = ev[ioc_pkg::EV_TX] | ev[ioc_pkg::EV_RX];
		spdOk = linkUp & (((spd == ioc_pkg::SPD_10T) & ~speed100) // see RULE_09
			| ((spd == ioc_pkg::SPD_100X) & speed100)); // see RULE_10
		case (code)
			ioc_pkg::SRC_COL: return {1'b0, ev[ioc_pkg::EV_COL]}; // see RULE_01
			ioc_pkg::SRC_ERR: return {1'b0, ev[ioc_pkg::EV_ERR]};
			ioc_pkg::SRC_DUP: return {1'b0, fullDuplex};
			ioc_pkg::SRC_DUP_COL: return {ev[ioc_pkg::EV_COL], fullDuplex};
			ioc_pkg::SRC_SPEED: return {1'b0, spdOk};
			ioc_pkg::SRC_LINK: return {1'b0, linkUp};
			ioc_pkg::SRC_TX: return {1'b0, ev[ioc_pkg::EV_TX]};
			ioc_pkg::SRC_RX: return {1'b0, ev[ioc_pkg::EV_RX]};
			ioc_pkg::SRC_ACTIVITY: return {1'b0, (idx != 0) & activity}; // see RULE_02
			ioc_pkg::SRC_LINK_RX: return {(idx != 0) & ev[ioc_pkg::EV_RX], (idx != 0) & linkUp};
			ioc_pkg::SRC_LINK_ACTIVITY: return {activity, linkUp};
			ioc_pkg::SRC_BL_ACTIVITY: return {activity, 1'b0}; // see RULE_03
			ioc_pkg::SRC_BL_TX: return {ev[ioc_pkg::EV_TX], 1'b0};
			ioc_pkg::SRC_BL_RX: return {ev[ioc_pkg::EV_RX], 1'b0};
			ioc_pkg::SRC_BL_COL_INT: begin // see RULE_04
				if (idx == 0) begin
					return {ev[ioc_pkg::EV_COL], 1'b0};
				end
				return {1'b0, (idx == 2) & intPending};
			end
			ioc_pkg::SRC_OFF: return 2'b00; // see RULE_05
			default: return 2'b00;
		endcase
	endfunction

	assign evIn = {rxActive, txActive, rxError, collision};
	assign stretchLen = stretchMs(timing_q[ioc_pkg::STRETCH_LSB +: 3]);
	assign halfMs = blinkHalf(timing_q[ioc_pkg::BLINK_LSB +: 3]);

	// APB decode; the slave never inserts wait states.
	assign setup = psel & ~penable;
	assign wrEn = psel & penable & pwrite;
	assign unmapped = (paddr != ioc_pkg::SRC_SEL_ADDR) & (paddr != ioc_pkg::TIMING_ADDR)
		& (paddr != ioc_pkg::STATUS_ADDR);
	assign pready = 1'b1;
	assign pslverr = psel & penable & unmapped;
	assign prdata = prdata_q;
	assign indicatorN = indicatorN_q;

	// Configuration registers ignore swReset so settings survive a soft reset.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			srcSel_q <= ioc_pkg::SRC_SEL_RST; // see RULE_06
		end else if (wrEn && paddr == ioc_pkg::SRC_SEL_ADDR) begin
			srcSel_q <= pwdata[15:0]; // see RULE_11
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timing_q <= ioc_pkg::TIMING_RST; // see RULE_07, RULE_08, RULE_10
		end else if (wrEn && paddr == ioc_pkg::TIMING_ADDR) begin
			timing_q <= pwdata[15:0] & ioc_pkg::TIMING_WR_MASK; // see RULE_11
		end
	end

	// Read data is captured in the setup phase so the access phase can finish at once.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			case (paddr)
				ioc_pkg::SRC_SEL_ADDR: prdata_q <= {16'h0000, srcSel_q};
				ioc_pkg::TIMING_ADDR: prdata_q <= {16'h0000, timing_q};
				ioc_pkg::STATUS_ADDR: prdata_q <= {25'h0000000, evS, litNow};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Event stretchers, one per raw event.
	for (genvar e = 0; e < ioc_pkg::NUM_EV; e++) begin : g_str
		logic [11:0] cnt_q;
		logic [14:0] pre_q;

		assign evS[e] = evIn[e] | (cnt_q != 12'h000);

		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				cnt_q <= 12'h000;
				pre_q <= 15'h0000;
			end else if (swReset) begin
				cnt_q <= 12'h000;
				pre_q <= 15'h0000;
			end else if (evIn[e]) begin
				cnt_q <= stretchLen; // see RULE_07
				if (cnt_q == 12'h000) begin
					pre_q <= 15'h0000; // see RULE_12
				end
			end else if (cnt_q != 12'h000) begin
				if (pre_q == TICK_LAST) begin
					pre_q <= 15'h0000;
					cnt_q <= cnt_q - 12'h001;
				end else begin
					pre_q <= pre_q + 15'h0001;
				end
			end
		end

		property p_stretch_load;
			@(posedge ref_clk) disable iff (rst)
			evIn[e] && !swReset |=> cnt_q == $past(stretchLen);
		endproperty
		a_stretch_load: assert property (p_stretch_load) // see RULE_07
			else $error("stretch counter not loaded with selected length");

		property p_stretch_fresh;
			@(posedge ref_clk) disable iff (rst)
			evIn[e] && cnt_q == 12'h000 && !swReset |=> pre_q == 15'h0000;
		endproperty
		a_stretch_fresh: assert property (p_stretch_fresh) // see RULE_12
			else $error("stretch prescaler not restarted after idle");

		property p_stretch_tick;
			@(posedge ref_clk) disable iff (rst)
			!evIn[e] && !swReset && cnt_q != 12'h000 && pre_q != TICK_LAST
				|=> $stable(cnt_q);
		endproperty
		a_stretch_tick: assert property (p_stretch_tick) // see RULE_12
			else $error("stretch counter moved off a prescaler tick");
	end

	// Per-output source mux, blink generator and pin register.
	for (genvar i = 0; i < ioc_pkg::NUM_IND; i++) begin : g_ind
		logic [1:0] pick;
		logic [3:0] code;
		logic [2:0] spd;
		logic phase_q;
		logic [14:0] bPre_q;
		logic [11:0] bMs_q;

		assign code = srcSel_q[i * ioc_pkg::SRC_W +: ioc_pkg::SRC_W];
		assign spd = timing_q[i * ioc_pkg::SPD_W +: ioc_pkg::SPD_W];
		// A process rather than an assign, so status inputs read inside the function wake it too.
		always_comb pick = pickSource(i, code, spd, evS);
		assign blinkOn[i] = pick[1];
		assign litNow[i] = pick[1] ? phase_q : pick[0];

		// The blink restarts lit whenever its source returns from idle.
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				phase_q <= 1'b1;
				bPre_q <= 15'h0000;
				bMs_q <= 12'h000;
			end else if (!blinkOn[i]) begin
				phase_q <= 1'b1; // see RULE_12
				bPre_q <= 15'h0000;
				bMs_q <= 12'h000;
			end else if (bPre_q == TICK_LAST) begin
				bPre_q <= 15'h0000;
				if (bMs_q >= halfMs - 12'h001) begin
					bMs_q <= 12'h000;
					phase_q <= ~phase_q; // see RULE_08
				end else begin
					bMs_q <= bMs_q + 12'h001;
				end
			end else begin
				bPre_q <= bPre_q + 15'h0001;
			end
		end

		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				indicatorN_q[i] <= 1'b1;
			end else begin
				indicatorN_q[i] <= ~litNow[i]; // see RULE_05
			end
		end

		sequence s_blink_start;
			$rose(blinkOn[i]);
		endsequence
		property p_blink_fresh;
			@(posedge ref_clk) disable iff (rst)
			s_blink_start |=> !indicatorN_q[i];
		endproperty
		a_blink_fresh: assert property (p_blink_fresh) // see RULE_03
			else $error("blink did not start in the lit phase");

		property p_blink_follow;
			@(posedge ref_clk) disable iff (rst)
			code == ioc_pkg::SRC_BL_TX && evS[ioc_pkg::EV_TX]
				|=> indicatorN_q[i] == !$past(phase_q);
		endproperty
		a_blink_follow: assert property (p_blink_follow) // see RULE_03
			else $error("blinking output did not follow its phase");

		property p_blink_rate;
			@(posedge ref_clk) disable iff (rst)
			blinkOn[i] && $past(blinkOn[i]) && phase_q != $past(phase_q)
				|-> $past(bPre_q) == TICK_LAST && $past(bMs_q) >= $past(halfMs) - 12'h001;
		endproperty
		a_blink_rate: assert property (p_blink_rate) // see RULE_08
			else $error("blink phase toggled off its period");

		property p_force_off;
			@(posedge ref_clk) disable iff (rst)
			code == ioc_pkg::SRC_OFF |=> indicatorN_q[i];
		endproperty
		a_force_off: assert property (p_force_off) // see RULE_05
			else $error("forced-inactive output was lit");
	end

	property p_collision;
		@(posedge ref_clk) disable iff (rst)
		srcSel_q[3:0] == ioc_pkg::SRC_COL && evS[ioc_pkg::EV_COL] |=> !indicatorN_q[0];
	endproperty
	a_collision: assert property (p_collision) // see RULE_01
		else $error("collision source did not light output 0");

	property p_no_act0;
		@(posedge ref_clk) disable iff (rst)
		srcSel_q[3:0] == ioc_pkg::SRC_ACTIVITY || srcSel_q[3:0] == ioc_pkg::SRC_LINK_RX
			|=> indicatorN_q[0];
	endproperty
	a_no_act0: assert property (p_no_act0) // see RULE_02
		else $error("output 0 lit on a code it does not offer");

	property p_interrupt;
		@(posedge ref_clk) disable iff (rst)
		srcSel_q[11:8] == ioc_pkg::SRC_BL_COL_INT && intPending |=> !indicatorN_q[2];
	endproperty
	a_interrupt: assert property (p_interrupt) // see RULE_04
		else $error("interrupt indication missing on output 2");

	property p_reset_vals;
		@(posedge ref_clk) disable iff (rst)
		$fell(rst) |-> srcSel_q == ioc_pkg::SRC_SEL_RST && timing_q == ioc_pkg::TIMING_RST;
	endproperty
	a_reset_vals: assert property (p_reset_vals) // see RULE_06
		else $error("configuration not at reset defaults after reset");

	property p_speed10;
		@(posedge ref_clk) disable iff (rst)
		srcSel_q[3:0] == ioc_pkg::SRC_SPEED && timing_q[2:0] == ioc_pkg::SPD_10T
			&& linkUp && !speed100 |=> !indicatorN_q[0];
	endproperty
	a_speed10: assert property (p_speed10) // see RULE_09
		else $error("10BASE-T link type select did not light output 0");

	property p_speed_other;
		@(posedge ref_clk) disable iff (rst)
		srcSel_q[3:0] == ioc_pkg::SRC_SPEED && timing_q[2:0] != ioc_pkg::SPD_10T
			&& timing_q[2:0] != ioc_pkg::SPD_100X |=> indicatorN_q[0];
	endproperty
	a_speed_other: assert property (p_speed_other) // see RULE_10
		else $error("reserved link type select lit output 0");

	property p_sw_keep;
		@(posedge ref_clk) disable iff (rst)
		swReset && !wrEn |=> $stable(srcSel_q) && $stable(timing_q);
	endproperty
	a_sw_keep: assert property (p_sw_keep) // see RULE_11
		else $error("software reset disturbed configuration");

	property p_timing_write;
		@(posedge ref_clk) disable iff (rst)
		wrEn && paddr == ioc_pkg::TIMING_ADDR
			|=> timing_q == ($past(pwdata[15:0]) & ioc_pkg::TIMING_WR_MASK);
	endproperty
	a_timing_write: assert property (p_timing_write) // see RULE_07
		else $error("timing register write not stored with its top bit clear");

endmodule

//--- common/ioc_pkg.sv
// Constants shared by the indicator output controller.
package ioc_pkg;

	// Timebase.
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

	// Register indices and byte addresses.
	localparam logic [7:0] SRC_SEL_IDX = 8'h16;
	localparam logic [7:0] TIMING_IDX = 8'h18;
	localparam logic [7:0] STATUS_IDX = 8'h1F;
	localparam logic [7:0] SRC_SEL_ADDR = 8'(SRC_SEL_IDX * 4);
	localparam logic [7:0] TIMING_ADDR = 8'(TIMING_IDX * 4);
	localparam logic [7:0] STATUS_ADDR = 8'(STATUS_IDX * 4);

	// Reset values and write masks.
	localparam logic [15:0] SRC_SEL_RST = 16'h4A44;
	localparam logic [15:0] TIMING_RST = 16'h4205;
	localparam logic [15:0] TIMING_WR_MASK = 16'h7FFF;

	// Field layout.
	localparam int SRC_W = 4;
	localparam int SPD_W = 3;
	localparam int STRETCH_LSB = 12;
	localparam int BLINK_LSB = 9;
	localparam int STAT_EV_LSB = 3;

	// Source selector codes.
	typedef enum logic [3:0] {
		SRC_COL = 4'h0, SRC_ERR = 4'h1, SRC_DUP = 4'h2, SRC_DUP_COL = 4'h3,
		SRC_SPEED = 4'h4, SRC_LINK = 4'h5, SRC_TX = 4'h6, SRC_RX = 4'h7,
		SRC_ACTIVITY = 4'h8, SRC_LINK_RX = 4'h9, SRC_LINK_ACTIVITY = 4'hA,
		SRC_BL_ACTIVITY = 4'hB,
		SRC_BL_TX = 4'hC, SRC_BL_RX = 4'hD, SRC_BL_COL_INT = 4'hE, SRC_OFF = 4'hF
	} ioc_src_e;

	// Link type codes.
	localparam logic [2:0] SPD_10T = 3'h0;
	localparam logic [2:0] SPD_100X = 3'h5;

	// Stretch and blink timing in milliseconds.
	localparam int unsigned STRETCH_BASE_MS = 21;
	localparam int unsigned BLINK_HALF_MS = 21;
	localparam logic [2:0] BLINK_MAX_SEL = 3'h4;

	// Stretched event indices.
	localparam int EV_COL = 0;
	localparam int EV_ERR = 1;
	localparam int EV_TX = 2;
	localparam int EV_RX = 3;
	localparam int NUM_EV = 4;
	localparam int NUM_IND = 3;

endpackage

//--- verification/ioc_indicator_ctrl_tb.sv
// Self-checking testbench for the indicator output controller.
`timescale 1ns/1ps

module ioc_indicator_ctrl_tb;
	localparam int TICK = 4;
	localparam logic [7:0] PAT [3] = '{8'hE2, 8'h5D, 8'h13};
	localparam int RATES [3] = '{0, 1, 5};
	logic ref_clk;
	logic rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	// Event inputs packed as {irq, link, 100M, duplex, rx, tx, err, col}.
	logic [7:0] stim;
	logic swReset;
	logic [2:0] indicatorN;
	logic [31:0] rdData;
	logic rdErr;
	int errTotal;
	int cmpCount;

	ioc_indicator_ctrl #(.TICK_CYC(TICK)) ioc_indicator_ctrl_inst (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.collision(stim[0]), .rxError(stim[1]), .txActive(stim[2]), .rxActive(stim[3]),
		.fullDuplex(stim[4]), .speed100(stim[5]), .linkUp(stim[6]), .intPending(stim[7]),
		.swReset(swReset), .indicatorN(indicatorN)
	);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmpCount, errTotal);
		if (errTotal == 0 && cmpCount > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic checkReg(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmpCount++;
		if (got !== exp) begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic checkPin(input string name, input logic [2:0] exp, input logic [2:0] got);
		cmpCount++;
		if (got !== exp) begin
			errTotal++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask

	// The request is held until pready is seen high or 16 more cycles pass, so a slave with up to 15 wait states is served.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 16) begin
			errTotal++;
			results();
		end
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic readCheck(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		checkReg(name, exp, rdData);
	endtask

	task automatic waitCyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic drive(input logic [7:0] v);
		@(posedge ref_clk);
		stim <= v;
	endtask

	// Pins seen shortly after a source turns on, so a blinking output is still in its lit phase.
	function automatic logic [2:0] expPins(input logic [3:0] c, input logic [7:0] s);
		logic [2:0] lit;
		logic activity;
		activity = s[2] | s[3];
		for (int o = 0; o < 3; o++) begin
			case (c)
				4'h0: lit[o] = s[0];
				4'h1: lit[o] = s[1];
				4'h2: lit[o] = s[4];
				4'h3: lit[o] = s[4] | s[0];
				4'h4: lit[o] = s[6] && (o == 0 ? s[5] : !s[5]);
				4'h5: lit[o] = s[6];
				4'h6: lit[o] = s[2];
				4'h7: lit[o] = s[3];
				4'h8: lit[o] = (o != 0) && activity;
				4'h9: lit[o] = (o != 0) && (s[6] | s[3]);
				4'hA: lit[o] = s[6] | activity;
				4'hB: lit[o] = activity;
				4'hC: lit[o] = s[2];
				4'hD: lit[o] = s[3];
				4'hE: lit[o] = (o == 0) ? s[0] : ((o == 2) ? s[7] : 1'b0);
				default: lit[o] = 1'b0;
			endcase
		end
		return ~lit;
	endfunction

	initial begin
		#(50 * 100000);
		errTotal++;
		$display("mismatch watchdog expected finish seen timeout");
		results();
	end

	initial begin
		int h;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		stim = 8'h00;
		swReset = 1'b0;
		errTotal = 0;
		cmpCount = 0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		readCheck("select reset", ioc_pkg::SRC_SEL_ADDR, 32'h0000_4A44);
		readCheck("timing reset", ioc_pkg::TIMING_ADDR, 32'h0000_4205);
		checkPin("idle pins", 3'b111, indicatorN);
		drive(8'h60);
		waitCyc(3);
		checkPin("default 100X", 3'b010, indicatorN);
		drive(8'h40);
		waitCyc(3);
		checkPin("default 10T", 3'b001, indicatorN);
		drive(8'h00);
		apb(1'b0, 8'h5C, 32'h0);
		checkReg("unmapped error", 32'h1, {31'h0, rdErr});
		checkReg("unmapped data", 32'h0, rdData);
		apb(1'b1, ioc_pkg::TIMING_ADDR, 32'h0000_FFFF);
		readCheck("timing top bit", ioc_pkg::TIMING_ADDR, 32'h0000_7FFF);
		apb(1'b1, ioc_pkg::TIMING_ADDR, 32'h0000_0005);
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, ioc_pkg::SRC_SEL_ADDR, {16'h0, 4'h4, 4'(c), 4'(c), 4'(c)});
			for (int p = 0; p < 3; p++) begin
				drive(PAT[p]);
				waitCyc(3);
				checkPin($sformatf("code %0h set %0d", c, p), expPins(4'(c), PAT[p]), indicatorN);
				drive(8'h00);
				waitCyc(2);
			end
		end
		apb(1'b1, ioc_pkg::SRC_SEL_ADDR, 32'h0000_4000);
		for (int n = 1; n < 4; n++) begin
			apb(1'b1, ioc_pkg::TIMING_ADDR, {16'h0, 1'b0, 3'(n), 12'h005});
			drive(8'h01);
			drive(8'h00);
			waitCyc((21 << (n - 1)) * TICK - 20);
			checkPin("stretch held", 3'b000, indicatorN);
			waitCyc(50);
			checkPin("stretch over", 3'b111, indicatorN);
		end
		drive(8'h01);
		drive(8'h00);
		waitCyc(5);
		readCheck("status stretched", ioc_pkg::STATUS_ADDR, 32'h0000_000F);
		@(posedge ref_clk);
		swReset <= 1'b1;
		@(posedge ref_clk);
		swReset <= 1'b0;
		waitCyc(3);
		checkPin("soft reset timer", 3'b111, indicatorN);
		readCheck("status cleared", ioc_pkg::STATUS_ADDR, 32'h0000_0000);
		readCheck("select kept", ioc_pkg::SRC_SEL_ADDR, 32'h0000_4000);
		readCheck("timing kept", ioc_pkg::TIMING_ADDR, 32'h0000_3005);
		apb(1'b1, ioc_pkg::SRC_SEL_ADDR, 32'h0000_4CCC);
		for (int i = 0; i < 3; i++) begin
			h = (21 << ((RATES[i] > 4) ? 4 : RATES[i])) * TICK;
			apb(1'b1, ioc_pkg::TIMING_ADDR, {16'h0, 4'h0, 3'(RATES[i]), 9'h005});
			drive(8'h04);
			waitCyc(h - 40);
			checkPin("blink lit", 3'b000, indicatorN);
			waitCyc(80);
			checkPin("blink dark", 3'b111, indicatorN);
			drive(8'h00);
			waitCyc(3);
		end
		results();
	end
endmodule
